// file: hw/ssrr_pkg.sv
/*
 * Constants for the sensor status and readout register bank:
 * register addresses, field positions, reset values and widths.
 * Assumes nothing of its surroundings; used by every design file.
 */
package ssrr_pkg;

    // ********
    // Widths
    // ********
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NV_WORDS = 22;
    localparam int NV_IDX_W = 5;
    localparam int ECC_W = 6;
    localparam int PAYLOAD_W = 26;
    localparam int FAULT_W = 13;

    // ********
    // Nonvolatile word addresses
    // ********
    localparam logic [7:0] NV_OUTPUT_INIT_HYST = 8'h05;
    localparam logic [7:0] NV_AXIS_ENABLE_ORTHOG = 8'h15;
    localparam logic [7:0] NV_ANGLE_THRESHOLD = 8'h16;
    localparam logic [7:0] NV_FIRST_AXIS_OFFSET = 8'h17;
    localparam logic [7:0] NV_FIRST_AXIS_SENS_TC2 = 8'h1B;
    localparam logic [7:0] NV_SECOND_AXIS_OFFSET = 8'h1C;
    localparam logic [7:0] NV_SECOND_AXIS_OFFS_TC1 = 8'h1D;
    localparam logic [7:0] NV_SECOND_AXIS_SENS_TC1 = 8'h1F;
    localparam logic [7:0] NV_TEMP_OFFS_SENS_TC2 = 8'h20;
    localparam logic [7:0] NV_LIN_COEFF_UPPER = 8'h31;
    localparam logic [7:0] NV_BIN_HYST_GAIN = 8'h33;
    localparam logic [7:0] NV_ANGLE_SAT_OFFSET = 8'h34;
    localparam logic [7:0] NV_FIELD_THRESHOLDS = 8'h35;
    localparam logic [7:0] NV_CLAMP_LOWER = 8'h36;
    localparam logic [7:0] NV_BANDWIDTH_CLAMP_UPPER = 8'h37;
    localparam logic [7:0] NV_DIGITAL_OUTPUT_CFG = 8'h39;
    localparam logic [7:0] NV_SERIAL_MSG_CFG = 8'h3A;
    localparam logic [7:0] NV_FAULT_MASKS = 8'h3B;
    localparam logic [7:0] NV_LOCK_ACCESS_CFG = 8'h3C;
    localparam logic [7:0] NV_SPARE_A = 8'h3D;
    localparam logic [7:0] NV_SPARE_B = 8'h3E;
    localparam logic [7:0] NV_SPARE_C = 8'h3F;
    localparam logic [7:0] SHADOW_OFFSET = 8'h40;

    // ********
    // Volatile word addresses
    // ********
    localparam logic [7:0] TEST_PORT_CONTROL = 8'hA0;
    localparam logic [7:0] SELFTEST_SIGNATURE = 8'hA1;
    localparam logic [7:0] FAULT_STATUS = 8'hA3;
    localparam logic [7:0] TEMP_ANGLE_READOUT = 8'hA7;
    localparam logic [7:0] AXIS_FINAL_READOUT = 8'hA8;
    localparam logic [7:0] AXIS_PREHYST_READOUT = 8'hA9;
    localparam logic [7:0] RADIUS_SQUARED_READOUT = 8'hAA;

    // ********
    // Field positions
    // ********
    localparam int CMD_MODE_BIT = 7;
    localparam int SELFTEST_START_BIT = 0;
    localparam int ECC_LSB = 26;
    localparam int HI_LSB = 16;
    localparam int HALF_W = 16;
    localparam int RADIUS_W = 17;
    localparam int OUT_DRIVE_SEL_BIT = 23;

    // Fault word bit positions
    localparam int F_OFE = 12;
    localparam int F_SPE = 11;
    localparam int F_EUE = 10;
    localparam int F_OVD = 9;
    localparam int F_UVD = 8;
    localparam int F_ESE = 7;
    localparam int F_POR = 6;
    localparam int F_SRR = 5;
    localparam int F_SLF = 4;
    localparam int F_SAT = 3;
    localparam int F_TSE = 2;
    localparam int F_AOC = 1;
    localparam int F_ACF = 0;

    // Mask bit positions inside the fault-mask word
    localparam int M_OVD = 11;
    localparam int M_UVD = 10;
    localparam int M_SPE = 9;
    localparam int M_ESE = 8;
    localparam int M_POR = 7;
    localparam int M_SRR = 6;
    localparam int M_SLF = 5;
    localparam int M_OFE = 4;
    localparam int M_SAT = 3;
    localparam int M_TSE = 2;
    localparam int M_AOC = 1;
    localparam int M_ACF = 0;

    // ********
    // Reset values
    // ********
    localparam logic [31:0] NV_RESET = 32'h0000_0000;
    localparam logic [31:0] READOUT_RESET = 32'h0000_0000;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

endpackage

// file: hw/ssrr_ecc_gen.sv
/*
 * Check-bit generator for nonvolatile and shadow words.
 * Assumes a 26-bit payload; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

module ssrr_ecc_gen (
    // Payload in
    input wire logic [ssrr_pkg::PAYLOAD_W-1:0] data_i,
    // Check bits out
    output logic [ssrr_pkg::ECC_W-1:0] ecc_o
);

    // ********
    // Hamming parity plus overall parity
    // ********
    // Five position parities give single-bit correction,
    // the sixth makes double errors detectable.
    always_comb begin
        logic [4:0] pos;
        ecc_o = '0;
        pos = '0;
        for (int i = 0; i < ssrr_pkg::PAYLOAD_W; i++) begin
            pos = 5'(i + 1);
            for (int k = 0; k < 5; k++) begin
                if (pos[k]) begin
                    ecc_o[k] = ecc_o[k] ^ data_i[i];
                end
            end
        end
        ecc_o[5] = (^data_i) ^ (^ecc_o[4:0]);
    end

endmodule

`default_nettype wire

// file: hw/ssrr_regs.sv
/*
 * Status and readout register bank of the angle sensor, with the
 * nonvolatile configuration words and their shadow copies.
 * Assumes a decoded command port from the single-wire command
 * link decoder and readout/fault sources on the same clock.
 */
// Function
// R1: Mode bit 0: normal output from config
// R2: Mode bit 1: output high impedance, commands
// R3: Self-test signature readable, compared with expected
// R4: Fault bits 12 to 8 as listed
// R5: Fault bits 7 to 4 as listed
// R6: Fault bits 3 to 0 as listed
// R7: Masked fault bits never assert
// R8: Temperature in upper half, two's complement
// R9: Angle readout in lower half
// R10: Final axis values, second upper
// R11: Prefilter axis values, second upper
// R12: Squared radius readable, decides radius fault
// R13: Shadow word at nonvolatile address plus 0x40
// R14: Top six bits hold check bits
// R15: Written check bits replaced, read back
// R16: Mode bit at bit 7 of 0xA0
// R17: Writes to read-only fields ignored
// R18: Readout halves captured from one update
`timescale 1ns/100ps
`default_nettype none

module ssrr_regs #(
    parameter logic [31:0] SELFTEST_EXPECTED = 32'h5A5A_0001, // arbitrary value
    parameter logic [16:0] RADIUS_SQ_MIN = 17'h0_0100,
    parameter logic [16:0] RADIUS_SQ_MAX = 17'h1_F000
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Decoded command port
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [ssrr_pkg::ADDR_W-1:0] cmd_addr_i,
    input wire logic [ssrr_pkg::DATA_W-1:0] cmd_wdata_i,
    output logic rsp_valid_o,
    output logic [ssrr_pkg::DATA_W-1:0] rsp_data_o,
    // Processing results
    input wire logic proc_update_i,
    input wire logic [15:0] temp_readout_i,
    input wire logic [15:0] angle_readout_i,
    input wire logic [15:0] first_axis_final_i,
    input wire logic [15:0] second_axis_final_i,
    input wire logic [15:0] first_axis_prefilter_i,
    input wire logic [15:0] second_axis_prefilter_i,
    input wire logic [16:0] squared_magnitude_i,
    // Self-test
    input wire logic selftest_done_i,
    input wire logic [31:0] selftest_sig_i,
    output logic selftest_start_o,
    output logic selftest_fail_o,
    // Raw fault conditions
    input wire logic [ssrr_pkg::FAULT_W-1:0] fault_raw_i,
    // Output control
    output logic out_hiz_o,
    output logic cmd_link_active_o,
    output logic out_open_drain_o,
    output logic [ssrr_pkg::FAULT_W-1:0] fault_o
);

    // Refuse layouts and radius windows the logic cannot serve
    if (ssrr_pkg::DATA_W != 32 || ssrr_pkg::NV_WORDS > 32 || RADIUS_SQ_MIN > RADIUS_SQ_MAX) begin : g_bad_cfg
        $error("ssrr_regs: unsupported configuration");
    end

    // ********
    // Address decode
    // ********
    function automatic logic [5:0] nv_index(input logic [7:0] a);
        logic [5:0] r;
        r = 6'h3F;
        case (a)
            ssrr_pkg::NV_OUTPUT_INIT_HYST: r = 6'h00;
            ssrr_pkg::NV_AXIS_ENABLE_ORTHOG: r = 6'h01;
            ssrr_pkg::NV_ANGLE_THRESHOLD: r = 6'h02;
            ssrr_pkg::NV_FIRST_AXIS_OFFSET: r = 6'h03;
            ssrr_pkg::NV_FIRST_AXIS_SENS_TC2: r = 6'h04;
            ssrr_pkg::NV_SECOND_AXIS_OFFSET: r = 6'h05;
            ssrr_pkg::NV_SECOND_AXIS_OFFS_TC1: r = 6'h06;
            ssrr_pkg::NV_SECOND_AXIS_SENS_TC1: r = 6'h07;
            ssrr_pkg::NV_TEMP_OFFS_SENS_TC2: r = 6'h08;
            ssrr_pkg::NV_LIN_COEFF_UPPER: r = 6'h09;
            ssrr_pkg::NV_BIN_HYST_GAIN: r = 6'h0A;
            ssrr_pkg::NV_ANGLE_SAT_OFFSET: r = 6'h0B;
            ssrr_pkg::NV_FIELD_THRESHOLDS: r = 6'h0C;
            ssrr_pkg::NV_CLAMP_LOWER: r = 6'h0D;
            ssrr_pkg::NV_BANDWIDTH_CLAMP_UPPER: r = 6'h0E;
            ssrr_pkg::NV_DIGITAL_OUTPUT_CFG: r = 6'h0F;
            ssrr_pkg::NV_SERIAL_MSG_CFG: r = 6'h10;
            ssrr_pkg::NV_FAULT_MASKS: r = 6'h11;
            ssrr_pkg::NV_LOCK_ACCESS_CFG: r = 6'h12;
            ssrr_pkg::NV_SPARE_A: r = 6'h13;
            ssrr_pkg::NV_SPARE_B: r = 6'h14;
            ssrr_pkg::NV_SPARE_C: r = 6'h15;
            default: r = 6'h3F;
        endcase
        return r;
    endfunction

    localparam logic [5:0] IDX_NONE = 6'h3F;
    localparam logic [4:0] IDX_OUT_CFG = 5'h00;
    localparam logic [4:0] IDX_MASKS = 5'h11;

    logic [5:0] nv_hit;
    logic [5:0] sh_hit;
    logic [4:0] nv_sel;
    logic [4:0] sh_sel;
    logic wr_cmd;
    logic rd_cmd;

    assign nv_hit = nv_index(cmd_addr_i);
    assign sh_hit = nv_index(8'(cmd_addr_i - ssrr_pkg::SHADOW_OFFSET)); // [R13]
    assign nv_sel = nv_hit[4:0];
    assign sh_sel = sh_hit[4:0];
    assign wr_cmd = cmd_valid_i && cmd_write_i;
    assign rd_cmd = cmd_valid_i && !cmd_write_i;

    // ********
    // Nonvolatile words and shadow copies
    // ********
    logic [31:0] nv_q [ssrr_pkg::NV_WORDS];
    logic [31:0] shadow_q [ssrr_pkg::NV_WORDS];
    logic [5:0] wr_ecc;
    logic [31:0] wr_word;

    ssrr_ecc_gen u_ecc (
        .data_i(cmd_wdata_i[ssrr_pkg::PAYLOAD_W-1:0]),
        .ecc_o(wr_ecc)
    );

    // Written check bits are dropped and recomputed
    assign wr_word = {wr_ecc, cmd_wdata_i[ssrr_pkg::PAYLOAD_W-1:0]}; // [R14] [R15]

    // A nonvolatile write also refreshes its shadow copy
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < ssrr_pkg::NV_WORDS; i++) begin
                nv_q[i] <= ssrr_pkg::NV_RESET;
            end
        end else if (wr_cmd && nv_hit != IDX_NONE) begin
            nv_q[nv_sel] <= wr_word;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < ssrr_pkg::NV_WORDS; i++) begin
                shadow_q[i] <= ssrr_pkg::NV_RESET;
            end
        end else if (wr_cmd && nv_hit != IDX_NONE) begin
            shadow_q[nv_sel] <= wr_word;
        end else if (wr_cmd && sh_hit != IDX_NONE) begin
            shadow_q[sh_sel] <= wr_word; // [R13]
        end
    end

    // ********
    // Control word: command mode and self-test start
    // ********
    logic cmd_mode_q;
    logic selftest_start_q;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cmd_mode_q <= ssrr_pkg::CONTROL_RESET[ssrr_pkg::CMD_MODE_BIT];
        end else if (wr_cmd && cmd_addr_i == ssrr_pkg::TEST_PORT_CONTROL) begin
            cmd_mode_q <= cmd_wdata_i[ssrr_pkg::CMD_MODE_BIT]; // [R16]
        end
    end

    // Start stays high until the self-test reports done or a control write clears bit 0
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            selftest_start_q <= ssrr_pkg::CONTROL_RESET[ssrr_pkg::SELFTEST_START_BIT];
        end else if (wr_cmd && cmd_addr_i == ssrr_pkg::TEST_PORT_CONTROL) begin
            selftest_start_q <= cmd_wdata_i[ssrr_pkg::SELFTEST_START_BIT];
        end else if (selftest_done_i) begin
            selftest_start_q <= 1'b0;
        end
    end

    // ********
    // Output mode
    // ********
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            out_hiz_o <= 1'b0;
            cmd_link_active_o <= 1'b0;
            out_open_drain_o <= 1'b0;
        end else begin
            out_hiz_o <= cmd_mode_q; // [R1] [R2]
            cmd_link_active_o <= cmd_mode_q; // [R2]
            out_open_drain_o <= shadow_q[IDX_OUT_CFG][ssrr_pkg::OUT_DRIVE_SEL_BIT]; // [R1]
        end
    end

    // ********
    // Self-test signature
    // ********
    logic [31:0] signature_q;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            signature_q <= ssrr_pkg::READOUT_RESET;
            selftest_fail_o <= 1'b0;
        end else if (selftest_done_i) begin
            signature_q <= selftest_sig_i; // [R3]
            selftest_fail_o <= (selftest_sig_i != SELFTEST_EXPECTED); // [R3]
        end
    end

    // ********
    // Readouts
    // ********
    logic [31:0] temp_angle_q;
    logic [31:0] axis_final_q;
    logic [31:0] axis_prefilter_q;
    logic [16:0] radius_sq_q;

    // All words load on the same update so halves never mix
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            temp_angle_q <= ssrr_pkg::READOUT_RESET;
            axis_final_q <= ssrr_pkg::READOUT_RESET;
            axis_prefilter_q <= ssrr_pkg::READOUT_RESET;
            radius_sq_q <= '0;
        end else if (proc_update_i) begin // [R18]
            temp_angle_q <= {temp_readout_i, angle_readout_i}; // [R8] [R9]
            axis_final_q <= {second_axis_final_i, first_axis_final_i}; // [R10]
            axis_prefilter_q <= {second_axis_prefilter_i, first_axis_prefilter_i}; // [R11]
            radius_sq_q <= squared_magnitude_i; // [R12]
        end
    end

    // ********
    // Fault word
    // ********
    logic por_pending_q;
    logic radius_bad;
    logic [12:0] mask_vec;
    logic [12:0] cond_vec;
    logic [31:0] mask_word;

    assign radius_bad = (radius_sq_q < RADIUS_SQ_MIN) || (radius_sq_q > RADIUS_SQ_MAX); // [R12]
    assign mask_word = shadow_q[IDX_MASKS];

    // Uncorrectable error has no mask and always reports
    always_comb begin
        mask_vec = '0;
        mask_vec[ssrr_pkg::F_OFE] = mask_word[ssrr_pkg::M_OFE];
        mask_vec[ssrr_pkg::F_SPE] = mask_word[ssrr_pkg::M_SPE];
        mask_vec[ssrr_pkg::F_OVD] = mask_word[ssrr_pkg::M_OVD];
        mask_vec[ssrr_pkg::F_UVD] = mask_word[ssrr_pkg::M_UVD];
        mask_vec[ssrr_pkg::F_ESE] = mask_word[ssrr_pkg::M_ESE];
        mask_vec[ssrr_pkg::F_POR] = mask_word[ssrr_pkg::M_POR];
        mask_vec[ssrr_pkg::F_SRR] = mask_word[ssrr_pkg::M_SRR];
        mask_vec[ssrr_pkg::F_SLF] = mask_word[ssrr_pkg::M_SLF];
        mask_vec[ssrr_pkg::F_SAT] = mask_word[ssrr_pkg::M_SAT];
        mask_vec[ssrr_pkg::F_TSE] = mask_word[ssrr_pkg::M_TSE];
        mask_vec[ssrr_pkg::F_AOC] = mask_word[ssrr_pkg::M_AOC];
        mask_vec[ssrr_pkg::F_ACF] = mask_word[ssrr_pkg::M_ACF];
    end

    always_comb begin
        cond_vec = fault_raw_i; // [R4] [R5] [R6]
        cond_vec[ssrr_pkg::F_POR] = fault_raw_i[ssrr_pkg::F_POR] || por_pending_q; // [R5]
        cond_vec[ssrr_pkg::F_SRR] = fault_raw_i[ssrr_pkg::F_SRR] || radius_bad; // [R5]
    end

    // Power-on flag holds until the fault word has been read once
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            por_pending_q <= 1'b1;
        end else if (rd_cmd && cmd_addr_i == ssrr_pkg::FAULT_STATUS) begin
            por_pending_q <= 1'b0;
        end
    end

    // Bits follow their conditions and clear when these go away
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fault_o <= '0;
        end else begin
            fault_o <= cond_vec & ~mask_vec; // [R7]
        end
    end

    // ********
    // Read path
    // ********
    logic [31:0] rd_word;
    logic rd_exists;

    // Writes to read-only addresses land nowhere above
    always_comb begin
        rd_word = '0;
        rd_exists = 1'b1;
        if (nv_hit != IDX_NONE) begin
            rd_word = nv_q[nv_sel]; // [R15]
        end else if (sh_hit != IDX_NONE) begin
            rd_word = shadow_q[sh_sel]; // [R13]
        end else begin
            case (cmd_addr_i)
                ssrr_pkg::TEST_PORT_CONTROL: begin
                    rd_word[ssrr_pkg::CMD_MODE_BIT] = cmd_mode_q;
                    rd_word[ssrr_pkg::SELFTEST_START_BIT] = selftest_start_q;
                end
                ssrr_pkg::SELFTEST_SIGNATURE: rd_word = signature_q; // [R3] [R17]
                ssrr_pkg::FAULT_STATUS: rd_word = 32'(fault_o); // [R17]
                ssrr_pkg::TEMP_ANGLE_READOUT: rd_word = temp_angle_q;
                ssrr_pkg::AXIS_FINAL_READOUT: rd_word = axis_final_q;
                ssrr_pkg::AXIS_PREHYST_READOUT: rd_word = axis_prefilter_q;
                ssrr_pkg::RADIUS_SQUARED_READOUT: rd_word = 32'(radius_sq_q); // [R12]
                default: rd_exists = 1'b0;
            endcase
        end
    end

    // Reads of absent addresses get no answer at all
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= '0;
        end else begin
            rsp_valid_o <= rd_cmd && rd_exists;
            if (rd_cmd && rd_exists) begin
                rsp_data_o <= rd_word;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            selftest_start_o <= 1'b0;
        end else begin
            selftest_start_o <= selftest_start_q;
        end
    end

endmodule

`default_nettype wire

// file: bench/ssrr_chk.sv
/*
 * Checker for the status and readout register bank, bound to its top.
 * Assumes the synchronous active-high reset and one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

module ssrr_chk #(
    parameter logic [31:0] SELFTEST_EXPECTED = 32'h5A5A_0001 // arbitrary value
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Command port
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [ssrr_pkg::ADDR_W-1:0] cmd_addr_i,
    input wire logic [ssrr_pkg::DATA_W-1:0] cmd_wdata_i,
    input wire logic rsp_valid_o,
    // Self-test and faults
    input wire logic selftest_done_i,
    input wire logic [31:0] selftest_sig_i,
    input wire logic selftest_fail_o,
    input wire logic [ssrr_pkg::FAULT_W-1:0] fault_raw_i,
    input wire logic [ssrr_pkg::FAULT_W-1:0] fault_o,
    // Output control
    input wire logic out_hiz_o,
    input wire logic cmd_link_active_o
);
    // ********
    // Assertions
    // ********
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    logic wr_ctl;
    assign wr_ctl = cmd_valid_i && cmd_write_i && cmd_addr_i == 8'hA0;

    property p_mode_on;
        wr_ctl && cmd_wdata_i[7] |-> ##2 out_hiz_o && cmd_link_active_o;
    endproperty
    a_mode_on: assert property (p_mode_on)
        else $error("mode bit set but output not released");
    property p_mode_off;
        wr_ctl && !cmd_wdata_i[7] |-> ##2 !out_hiz_o && !cmd_link_active_o;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("mode bit clear but output still released");
    property p_hiz_link;
        out_hiz_o == cmd_link_active_o;
    endproperty
    a_hiz_link: assert property (p_hiz_link)
        else $error("high impedance and link activity disagree");
    property p_sig_read;
        cmd_valid_i && !cmd_write_i && cmd_addr_i == 8'hA1 |=> rsp_valid_o;
    endproperty
    a_sig_read: assert property (p_sig_read)
        else $error("signature read not answered");
    property p_st_fail;
        selftest_done_i |=> selftest_fail_o == ($past(selftest_sig_i) != SELFTEST_EXPECTED);
    endproperty
    a_st_fail: assert property (p_st_fail)
        else $error("self-test verdict wrong");
    property p_write_quiet;
        cmd_valid_i && cmd_write_i |=> !rsp_valid_o;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("write produced an answer");
    property p_uncorr;
        !$past(rst_i) |-> fault_o[10] == $past(fault_raw_i[10]);
    endproperty
    a_uncorr: assert property (p_uncorr)
        else $error("uncorrectable flag does not follow its condition");
    property p_no_spurious;
        !$past(rst_i) |-> (fault_o & ~$past(fault_raw_i) & 13'h1F9F) == 13'h0000;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("fault flag set without its condition");
endmodule

bind ssrr_regs ssrr_chk #(.SELFTEST_EXPECTED(SELFTEST_EXPECTED)) u_chk (.mclk_i, .rst_i, .cmd_valid_i,
    .cmd_write_i, .cmd_addr_i, .cmd_wdata_i, .rsp_valid_o, .selftest_done_i, .selftest_sig_i,
    .selftest_fail_o, .fault_raw_i, .fault_o, .out_hiz_o, .cmd_link_active_o);

`default_nettype wire

// file: bench/ssrr_prog.sv
/*
 * Programmer model: issues decoded reads and writes on the command port.
 * Assumes the bank samples commands on the rising edge of mclk_i.
 */
`timescale 1ns/100ps
`default_nettype none

module ssrr_prog (
    // Clock
    input wire logic mclk_i,
    // Command port
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [7:0] cmd_addr_o,
    output logic [31:0] cmd_wdata_o,
    // Answer
    input wire logic rsp_valid_i,
    input wire logic [31:0] rsp_data_i
);
    // ********
    // Command tasks
    // ********
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_addr_o = 8'h00;
        cmd_wdata_o = 32'h0000_0000;
    end

    // Released lines show inverted values so stale data cannot pass
    task automatic issue(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(negedge mclk_i);
        cmd_valid_o = 1'b1;
        cmd_write_o = wr;
        cmd_addr_o = a;
        cmd_wdata_o = d;
        @(negedge mclk_i);
        cmd_valid_o = 1'b0;
        cmd_write_o = ~wr;
        cmd_addr_o = ~a;
        cmd_wdata_o = ~d;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        issue(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, output logic ok, output logic [31:0] q);
        issue(1'b0, a, 32'h0000_0000);
        ok = rsp_valid_i;
        q = rsp_data_i;
    endtask
endmodule

`default_nettype wire

// file: bench/sensor_status_readout_regs_test.sv
/*
 * Self-checking bench for the status and readout register bank.
 * Assumes the programmer model and the bound checker are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end

module sensor_status_readout_regs_test;
    localparam logic [31:0] EXP_SIG = 32'h5A5A_0001; // arbitrary value
    logic mclk_i = 1'b0, rst_i = 1'b1, proc_update_i = 1'b0, selftest_done_i = 1'b0, ok;
    logic [15:0] tmp = 16'h0000, ang = 16'h0000, fa = 16'h0000, sa = 16'h0000;
    logic [15:0] fp = 16'h0000, sp = 16'h0000;
    logic [16:0] rad = 17'h0_0000;
    logic [12:0] fault_raw_i = 13'h0000;
    logic [31:0] selftest_sig_i = 32'h0000_0000, rdq;
    wire logic cmd_valid_i, cmd_write_i, rsp_valid_o, selftest_start_o, selftest_fail_o;
    wire logic out_hiz_o, cmd_link_active_o, out_open_drain_o;
    wire logic [7:0] cmd_addr_i;
    wire logic [31:0] cmd_wdata_i, rsp_data_o;
    wire logic [12:0] fault_o;
    int error_cnt = 0, checked = 0, cyc = 0;

    ssrr_regs #(.SELFTEST_EXPECTED(EXP_SIG)) dut (.mclk_i, .rst_i, .cmd_valid_i, .cmd_write_i,
        .cmd_addr_i, .cmd_wdata_i, .rsp_valid_o, .rsp_data_o, .proc_update_i, .temp_readout_i(tmp),
        .angle_readout_i(ang), .first_axis_final_i(fa), .second_axis_final_i(sa),
        .first_axis_prefilter_i(fp), .second_axis_prefilter_i(sp), .squared_magnitude_i(rad),
        .selftest_done_i, .selftest_sig_i, .selftest_start_o, .selftest_fail_o, .fault_raw_i,
        .out_hiz_o, .cmd_link_active_o, .out_open_drain_o, .fault_o);
    ssrr_prog prog (.mclk_i, .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
        .cmd_addr_o(cmd_addr_i), .cmd_wdata_o(cmd_wdata_i), .rsp_valid_i(rsp_valid_o),
        .rsp_data_i(rsp_data_o));

    // ********
    // Helpers
    // ********
    initial forever #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic pulse_upd();
        proc_update_i = 1'b1;
        wt(1);
        proc_update_i = 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        prog.rd(a, ok, rdq);
        `CHK(n, 1'b1, ok)
        `CHK(n, e, rdq)
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_por();
        wt(3);
        `CHK("por flag", 1'b1, fault_o[6])
        rd_chk("fault word", 8'hA3, 32'h0000_0060);
        wt(1);
        `CHK("por cleared", 1'b0, fault_o[6])
        rd_chk("shadow reset", 8'h45, 32'h0000_0000);
    endtask
    task automatic t_mode();
        prog.wr(8'hA0, 32'h0000_0080);
        wt(1);
        `CHK("hiz", 1'b1, out_hiz_o)
        `CHK("link", 1'b1, cmd_link_active_o)
        rd_chk("control", 8'hA0, 32'h0000_0080);
        prog.wr(8'hA0, 32'h0000_0000);
        wt(1);
        `CHK("normal", 1'b0, out_hiz_o)
    endtask
    task automatic t_readout();
        {tmp, ang, fa, sa, fp, sp, rad} = {16'hF380, 16'h1234, 16'hA5A5, 16'h5A5A, 16'h0F0F, 16'hF0F0, 17'h1_0000};
        pulse_upd();
        tmp = 16'h0001;
        rd_chk("temp angle", 8'hA7, 32'hF380_1234);
        rd_chk("axis final", 8'hA8, 32'h5A5A_A5A5);
        rd_chk("axis pre", 8'hA9, 32'hF0F0_0F0F);
        rd_chk("radius", 8'hAA, 32'h0001_0000);
        prog.wr(8'hA7, 32'hFFFF_FFFF);
        rd_chk("ro write", 8'hA7, 32'hF380_1234);
        `CHK("radius ok", 1'b0, fault_o[5])
        rad = 17'h1_F001;
        pulse_upd();
        wt(2);
        `CHK("radius high", 1'b1, fault_o[5])
        rad = 17'h1_0000;
        pulse_upd();
        wt(2);
    endtask
    task automatic t_faults();
        for (int i = 0; i < 13; i++) begin
            fault_raw_i = 13'h0001 << i;
            wt(2);
            `CHK("fault bit", fault_raw_i, fault_o)
        end
        fault_raw_i = 13'h1555;
        wt(2);
        rd_chk("fault read", 8'hA3, 32'h0000_1555);
    endtask
    task automatic t_mask();
        prog.wr(8'h3B, 32'h0000_0FFF);
        fault_raw_i = 13'h1FFF;
        wt(2);
        `CHK("masked", 13'h0400, fault_o)
        prog.rd(8'h7B, ok, rdq);
        `CHK("shadow copy", 26'h000_0FFF, rdq[25:0])
        prog.wr(8'h7B, 32'h0000_0000);
        wt(2);
        `CHK("unmasked", 13'h1FFF, fault_o)
    endtask
    task automatic t_ecc();
        prog.wr(8'h45, 32'h0080_0000);
        wt(1);
        `CHK("open drain", 1'b1, out_open_drain_o)
        rd_chk("ecc made", 8'h45, 32'hE080_0000);
        prog.wr(8'h45, 32'hFC80_0000);
        rd_chk("ecc kept", 8'h45, 32'hE080_0000);
        `CHK("payload", 26'h080_0000, rdq[25:0])
        `CHK("ecc field", 6'h38, rdq[31:26])
    endtask
    task automatic t_selftest();
        prog.wr(8'hA0, 32'h0000_0001);
        wt(1);
        `CHK("st start", 1'b1, selftest_start_o)
        selftest_sig_i = 32'h0BAD_0000;
        selftest_done_i = 1'b1;
        wt(1);
        selftest_done_i = 1'b0;
        `CHK("st fail", 1'b1, selftest_fail_o)
        rd_chk("signature", 8'hA1, 32'h0BAD_0000);
        selftest_sig_i = EXP_SIG;
        selftest_done_i = 1'b1;
        wt(1);
        selftest_done_i = 1'b0;
        `CHK("st pass", 1'b0, selftest_fail_o)
        prog.wr(8'hA1, 32'h0000_0000);
        rd_chk("sig ro", 8'hA1, EXP_SIG);
        prog.rd(8'hA2, ok, rdq);
        `CHK("unmapped", 1'b0, ok)
    endtask

    initial begin
        wt(10);
        rst_i = 1'b0;
        t_por();
        t_mode();
        t_readout();
        t_faults();
        t_mask();
        t_ecc();
        t_selftest();
        tally_and_finish();
    end
endmodule

`default_nettype wire
